// file: pkg/prs_pkg.sv
// shared constants, types and decode helpers of the reset sequencer
package prs_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_NS  = 20;
  localparam int RC_TICK_NS     = 1000;
  localparam int RC_DIV_CYC     = RC_TICK_NS / CLK_PERIOD_NS;
  localparam int RC_DIV_W       = $clog2(RC_DIV_CYC);
  localparam int POWER_UP_TIMER_MS        = 72;
  localparam int POWER_UP_TIMER_TICKS_NOM = POWER_UP_TIMER_MS * 1000000 / RC_TICK_NS;
  localparam int OST_CYCLES     = 1024;
  localparam int EXT_FILT_NS    = 200;
  localparam int EXT_FILT_CYC   =
    (EXT_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXT_FILT_W     = $clog2(EXT_FILT_CYC + 1);
  localparam int DLY_CNT_W      = 17;

  // ==========================================================
  // register map (index times four gives the byte address)
  localparam logic [7:0]  STATUS_IDX  = 8'h03;
  localparam logic [7:0]  POWER_CONTROL_IDX    = 8'h8E;
  localparam logic [11:0] STATUS_ADDR = {2'b00, STATUS_IDX, 2'b00};
  localparam logic [11:0] POWER_CONTROL_ADDR   = {2'b00, POWER_CONTROL_IDX, 2'b00};

  // ==========================================================
  // field positions
  localparam int STAT_TO_BIT  = 4;
  localparam int STAT_PD_BIT  = 3;
  localparam int POWER_CONTROL_POR_BIT = 1;

  // ==========================================================
  // reset values
  localparam logic [7:0]  STATUS_POR_VAL = 8'h18;
  localparam logic        POWER_CONTROL_POR_VAL   = 1'b0;
  localparam logic [7:0]  OPTION_RST_VAL = 8'hFF;
  localparam logic [7:0]  TRIS_RST_VAL   = 8'hFF;
  localparam logic [7:0]  PCL_RST_VAL    = 8'h00;
  localparam logic [7:0]  UPPER_ADDRESS_LATCH_RST_VAL = 8'h00;
  localparam logic [7:0]  IRQ_CONTROL_REG_RST_VAL = 8'h00;
  localparam logic [12:0] PC_RESET_VEC   = 13'h0000;
  localparam logic [12:0] PC_IRQ_VEC     = 13'h0004;

  // ==========================================================
  // oscillator selection codes
  typedef logic [1:0] prs_osc_t;
  localparam prs_osc_t RESISTOR_CAP_MODE       = 2'b11;
  localparam prs_osc_t CRYSTAL_HIGH_SPEED_MODE = 2'b10;
  localparam prs_osc_t CRYSTAL_STANDARD_MODE   = 2'b01;
  localparam prs_osc_t CRYSTAL_LOW_POWER_MODE  = 2'b00;

  typedef enum logic [2:0] {
    ST_POR, ST_POWER_UP_TIMER, ST_OST, ST_HOLD, ST_RUN, ST_SLEEP, ST_WAKE
  } prs_state_t;

  function automatic logic prs_is_crystal(input prs_osc_t sel);
    prs_is_crystal = (sel == CRYSTAL_HIGH_SPEED_MODE) ||
                     (sel == CRYSTAL_STANDARD_MODE) ||
                     (sel == CRYSTAL_LOW_POWER_MODE);
  endfunction

endpackage

// file: rtl/prs_delay_cnt.sv
// tick-driven one-shot delay counter with a done pulse
`timescale 1ns/1ps
module prs_delay_cnt
  import prs_pkg::*;
#(
  parameter int CNT_W = DLY_CNT_W
) (
  input  wire logic             clk_sys, // system clock
  input  wire logic             rst_b,   // async reset, active low
  input  wire logic             start,   // restart the delay
  input  wire logic             tick,    // one count per pulse
  input  wire logic [CNT_W-1:0] limit,   // ticks to count, at least 1
  output logic                  busy_q,  // counting
  output logic                  done_q   // pulse when limit reached
);

  logic [CNT_W-1:0] count_q;
  wire              last_w = (count_q == limit - 1'b1);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= '0;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        count_q <= '0;
        busy_q  <= 1'b1;
      end else if (busy_q && tick) begin
        count_q <= count_q + 1'b1;
        if (last_w) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

endmodule

// file: rtl/prs_top.sv
// power-on reset and start-up sequencer with cause flags over apb
`timescale 1ns/1ps
module prs_top
  import prs_pkg::*;
#(
  parameter int POWER_UP_TIMER_TICKS = POWER_UP_TIMER_TICKS_NOM
) (
  input  wire logic        clk_sys,                // 50 MHz clock
  input  wire logic        rst_b,                  // async reset, low
  input  wire logic        supply_rise_det,        // power-on pulse
  input  wire logic        external_reset_pin_n,   // reset pin, low
  input  wire logic        watchdog_timer_timeout, // timeout pulse
  input  wire logic        sleep_enter,            // core enters sleep
  input  wire logic        irq_wake,               // enabled irq pending
  input  wire logic        global_irq_enable,      // core enable bit
  input  wire logic        power_up_timer_disable, // config bit
  input  wire logic [1:0]  osc_select_bits,        // config bits
  input  wire logic        osc_in,                 // oscillator input
  input  wire logic        psel,                   // apb select
  input  wire logic        penable,                // apb enable
  input  wire logic        pwrite,                 // apb direction
  input  wire logic [11:0] paddr,                  // apb byte address
  input  wire logic [31:0] pwdata,                 // apb write data
  output logic             pready_q,               // apb ready
  output logic [31:0]      prdata_q,               // apb read data
  output logic             pslverr_q,              // apb error
  output logic             core_reset_n_q,         // core reset, low
  output logic             reg_init_q,             // load reset state
  output logic             gie_clear_q,            // clear irq enable
  output logic             pc_load_q,              // load pc pulse
  output logic [12:0]      pc_value_q,             // pc value to load
  output logic             wake_resume_q,          // resume after sleep
  output logic [7:0]       status_q,               // status flags
  output logic             power_control_por_q              // power-on flag
);

  // ==========================================================
  // oscillator decode and rc tick divider
  wire xtal_w = prs_is_crystal(osc_select_bits);
  wire rc_w   = (osc_select_bits == RESISTOR_CAP_MODE);

  localparam logic [RC_DIV_W-1:0] RC_LAST = RC_DIV_W'(RC_DIV_CYC - 1);
  localparam logic [DLY_CNT_W-1:0] POWER_UP_TIMER_LIM = DLY_CNT_W'(POWER_UP_TIMER_TICKS);
  localparam logic [DLY_CNT_W-1:0] OST_LIM  = DLY_CNT_W'(OST_CYCLES);
  localparam logic [EXT_FILT_W-1:0] FILT_LAST =
    EXT_FILT_W'(EXT_FILT_CYC - 1);

  logic [RC_DIV_W-1:0] rc_div_q;
  logic                rc_tick_q;
  logic                osc_d_q;

  // the rc tick keeps the power-up delay independent of osc_in
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rc_div_q  <= '0;
      rc_tick_q <= 1'b0;
      osc_d_q   <= 1'b0;
    end else begin
      rc_div_q  <= (rc_div_q == RC_LAST) ? '0 : rc_div_q + 1'b1;
      rc_tick_q <= (rc_div_q == RC_LAST);
      osc_d_q   <= osc_in;
    end
  end

  wire osc_edge_w = osc_in & ~osc_d_q;

  // ==========================================================
  // reset pin noise filter
  logic [EXT_FILT_W-1:0] filt_cnt_q;
  logic                  ext_filt_q;
  wire                   filt_diff_w = (external_reset_pin_n != ext_filt_q);

  // pulses shorter than the filter length never reach ext_filt_q
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      filt_cnt_q <= '0;
      ext_filt_q <= 1'b1;
    end else if (!filt_diff_w) begin
      filt_cnt_q <= '0;
    end else if (filt_cnt_q == FILT_LAST) begin
      filt_cnt_q <= '0;
      ext_filt_q <= external_reset_pin_n;
    end else begin
      filt_cnt_q <= filt_cnt_q + 1'b1;
    end
  end

  wire ext_low_w = ~ext_filt_q;

  // ==========================================================
  // delay timers
  logic start_power_up_timer, start_ost;
  logic power_up_timer_done, ost_done;

  prs_delay_cnt #(.CNT_W(DLY_CNT_W)) u_power_up_timer (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .start   (start_power_up_timer),
    .tick    (rc_tick_q),
    .limit   (POWER_UP_TIMER_LIM),
    .busy_q  (),
    .done_q  (power_up_timer_done)
  );

  prs_delay_cnt #(.CNT_W(DLY_CNT_W)) u_ost (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .start   (start_ost),
    .tick    (osc_edge_w),
    .limit   (OST_LIM),
    .busy_q  (),
    .done_q  (ost_done)
  );

  // ==========================================================
  // sequencer
  prs_state_t state_q, state_d;
  logic       wake_irq_q;
  wire        power_up_timer_en_w = ~power_up_timer_disable;

  always_comb begin
    state_d    = state_q;
    start_power_up_timer = 1'b0;
    start_ost  = 1'b0;
    unique case (state_q)
      ST_POR: begin
        if (!supply_rise_det) begin
          if (power_up_timer_en_w) begin
            state_d    = ST_POWER_UP_TIMER;
            start_power_up_timer = 1'b1;
          end else if (xtal_w) begin
            state_d   = ST_OST;
            start_ost = 1'b1;
          end else begin
            state_d = ST_HOLD;
          end
        end
      end
      ST_POWER_UP_TIMER: begin
        if (power_up_timer_done && xtal_w) begin
          state_d   = ST_OST;
          start_ost = 1'b1;
        end else if (power_up_timer_done) begin
          state_d = ST_HOLD;
        end
      end
      ST_OST: if (ost_done) state_d = ST_HOLD;
      ST_HOLD: if (!ext_low_w) state_d = ST_RUN;
      ST_RUN: begin
        if (ext_low_w || watchdog_timer_timeout) begin
          state_d = ST_HOLD;
        end else if (sleep_enter) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (ext_low_w) begin
          state_d = ST_HOLD;
        end else if (watchdog_timer_timeout || irq_wake) begin
          state_d   = xtal_w ? ST_WAKE : ST_RUN;
          start_ost = xtal_w;
        end
      end
      ST_WAKE: begin
        if (ext_low_w) state_d = ST_HOLD;
        else if (ost_done) state_d = ST_RUN;
      end
    endcase
    if (supply_rise_det) begin
      state_d = ST_POR;
    end
  end

  // ==========================================================
  // cause events
  wire ev_por_w       = supply_rise_det;
  wire ev_ext_run_w   = (state_q == ST_RUN) && ext_low_w;
  wire ev_wdt_rst_w   = (state_q == ST_RUN) && !ext_low_w &&
                        watchdog_timer_timeout;
  wire ev_sleep_w     = (state_q == ST_RUN) && !ext_low_w &&
                        !watchdog_timer_timeout && sleep_enter;
  wire ev_ext_slp_w   = (state_q == ST_SLEEP) && ext_low_w;
  wire ev_wdt_wake_w  = (state_q == ST_SLEEP) && !ext_low_w &&
                        watchdog_timer_timeout;
  wire ev_irq_wake_w  = (state_q == ST_SLEEP) && !ext_low_w &&
                        !watchdog_timer_timeout && irq_wake;
  wire rel_reset_w    = (state_q == ST_HOLD) && (state_d == ST_RUN);
  wire rel_wake_w     = (state_d == ST_RUN) &&
                        ((state_q == ST_WAKE) || (state_q == ST_SLEEP));
  wire core_run_d     = (state_d == ST_RUN) || (state_d == ST_SLEEP) ||
                        (state_d == ST_WAKE);

  // ==========================================================
  // apb slave, one wait state
  wire access_w  = psel && penable && pready_q;
  wire hit_st_w  = (paddr == STATUS_ADDR);
  wire hit_pc_w  = (paddr == POWER_CONTROL_ADDR);
  wire wr_st_w   = access_w && pwrite && hit_st_w;
  wire wr_pc_w   = access_w && pwrite && hit_pc_w;
  wire [31:0] rd_mux_w = hit_st_w ? {24'h000000, status_q} :
                         hit_pc_w ? {30'h00000000, power_control_por_q, 1'b0} :
                         32'h00000000;

  // hardware cause loads win over a software write in the same cycle
  wire [7:0] st_sw_w  = {pwdata[7:5], status_q[STAT_TO_BIT],
                         status_q[STAT_PD_BIT], pwdata[2:0]};
  wire [7:0] status_d =
    ev_por_w      ? STATUS_POR_VAL :
    ev_ext_run_w  ? {3'b000, status_q[4:0]} :
    ev_ext_slp_w  ? {3'b000, 2'b10, status_q[2:0]} :
    ev_wdt_rst_w  ? {3'b000, 1'b0, status_q[3:0]} :
    ev_wdt_wake_w ? {status_q[7:5], 2'b00, status_q[2:0]} :
    ev_irq_wake_w ? {status_q[7:5], 2'b10, status_q[2:0]} :
    ev_sleep_w    ? {status_q[7:5], 2'b10, status_q[2:0]} :
    wr_st_w       ? st_sw_w : status_q;
  wire power_control_d = ev_por_w ? POWER_CONTROL_POR_VAL :
                wr_pc_w  ? pwdata[POWER_CONTROL_POR_BIT] : power_control_por_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel && penable && !pready_q;
      prdata_q  <= (psel && penable && !pready_q && !pwrite) ?
                   rd_mux_w : 32'h00000000;
      pslverr_q <= psel && penable && !pready_q && !hit_st_w && !hit_pc_w;
    end
  end

  // ==========================================================
  // state, flags and core-facing outputs
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q        <= ST_POR;
      wake_irq_q     <= 1'b0;
      status_q       <= STATUS_POR_VAL;
      power_control_por_q     <= POWER_CONTROL_POR_VAL;
      core_reset_n_q <= 1'b0;
      reg_init_q     <= 1'b0;
      gie_clear_q    <= 1'b0;
      pc_load_q      <= 1'b0;
      pc_value_q     <= PC_RESET_VEC;
      wake_resume_q  <= 1'b0;
    end else begin
      state_q        <= state_d;
      status_q       <= status_d;
      power_control_por_q     <= power_control_d;
      core_reset_n_q <= core_run_d;
      if (ev_wdt_wake_w || ev_irq_wake_w) begin
        wake_irq_q <= ev_irq_wake_w;
      end
      // working registers are left alone; only the init strobe acts
      reg_init_q    <= rel_reset_w;
      gie_clear_q   <= rel_reset_w;
      wake_resume_q <= rel_wake_w;
      pc_load_q     <= rel_reset_w ||
                       (rel_wake_w && wake_irq_q && global_irq_enable);
      if (rel_reset_w) begin
        pc_value_q <= PC_RESET_VEC;
      end else if (rel_wake_w && wake_irq_q && global_irq_enable) begin
        pc_value_q <= PC_IRQ_VEC;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  power_up_timer_hold_a: assert property (state_q == ST_POWER_UP_TIMER |=> !core_reset_n_q)
    else $error("core released while power-up timer runs");
  power_up_timer_skip_a: assert property (
    state_q == ST_POR && !supply_rise_det && power_up_timer_disable
    |=> state_q != ST_POWER_UP_TIMER)
    else $error("power-up timer ran while disabled");
  ost_order_a: assert property (
    state_q == ST_POWER_UP_TIMER && power_up_timer_done && xtal_w && !supply_rise_det
    |=> state_q == ST_OST)
    else $error("oscillator delay did not follow power-up timer");
  rc_fast_a: assert property (
    state_q == ST_POR && !supply_rise_det && power_up_timer_disable &&
    rc_w && ext_filt_q && filt_cnt_q == '0 ##1 !supply_rise_det
    |=> core_reset_n_q)
    else $error("rc mode release was delayed");
  pin_release_a: assert property (
    state_q == ST_HOLD && ext_filt_q && !supply_rise_det
    |=> core_reset_n_q && reg_init_q && gie_clear_q)
    else $error("pin release did not start the core at once");
  por_flag_a: assert property (supply_rise_det |=> !power_control_por_q)
    else $error("power-on flag not cleared");
  por_status_a: assert property (
    supply_rise_det |=> status_q == STATUS_POR_VAL)
    else $error("status not loaded for power-on");
  wdt_flags_a: assert property (
    ev_wdt_rst_w && !supply_rise_det
    |=> !status_q[STAT_TO_BIT] &&
        status_q[STAT_PD_BIT] == $past(status_q[STAT_PD_BIT]))
    else $error("watchdog reset flags wrong");
  filt_len_a: assert property (
    $changed(ext_filt_q) |-> $past(filt_cnt_q) == FILT_LAST)
    else $error("filter passed a short pulse");
  reset_pc_a: assert property (
    rel_reset_w |=> pc_load_q && pc_value_q == PC_RESET_VEC)
    else $error("reset vector not loaded");

  por_seq_c:  cover property (state_q == ST_OST ##1 state_q == ST_HOLD
                              ##[1:50] state_q == ST_RUN);
  wdt_wake_c: cover property (wake_resume_q && !wake_irq_q);
  ext_slp_c:  cover property (ev_ext_slp_w);
  irq_vec_c:  cover property (pc_load_q && pc_value_q == PC_IRQ_VEC);

endmodule

// file: tb/prs_core_model.sv
// core and crystal model on the far side of the reset sequencer
`timescale 1ns/1ps
module prs_core_model (
  input  wire logic        clk_sys,       // system clock
  input  wire logic        rst_b,         // async reset, low
  input  wire logic        pc_load_q,     // pc load pulse
  input  wire logic [12:0] pc_value_q,    // pc value to load
  input  wire logic        wake_resume_q, // wake complete pulse
  input  wire logic        reg_init_q,    // reset state load pulse
  input  wire logic        gie_clear_q,   // irq enable clear pulse
  output logic             osc_in,        // crystal output
  output logic [12:0]      pc_seen,       // last loaded pc
  output int               wake_cnt,      // wake pulses seen
  output int               init_cnt,      // reset loads seen
  output int               gie_cnt        // enable clears seen
);
  // ==========================================================
  // crystal: free running, one rising edge every two clocks
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) osc_in <= 1'b0;
    else osc_in <= ~osc_in;
  end

  // ==========================================================
  // core side: keeps what the sequencer hands over
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pc_seen  <= 13'h1FFF;
      wake_cnt <= 0;
      init_cnt <= 0;
      gie_cnt  <= 0;
    end else begin
      if (pc_load_q) pc_seen <= pc_value_q;
      if (wake_resume_q) wake_cnt <= wake_cnt + 1;
      if (reg_init_q) init_cnt <= init_cnt + 1;
      if (gie_clear_q) gie_cnt <= gie_cnt + 1;
    end
  end
endmodule

// file: tb/testbench.sv
// self-checking bench for the reset sequencer
`timescale 1ns/1ps
module testbench;
  import prs_pkg::*;
  localparam int PT   = 20;
  localparam int PUTC = PT * RC_DIV_CYC;
  localparam int OSTC = 2 * OST_CYCLES;
  logic        clk_sys, rst_b, supply_rise_det, external_reset_pin_n;
  logic        watchdog_timer_timeout, sleep_enter, irq_wake;
  logic        global_irq_enable, power_up_timer_disable, osc_in;
  logic        psel, penable, pwrite, pready_q, pslverr_q, err;
  logic [1:0]  osc_select_bits;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_q, rd;
  logic        core_reset_n_q, reg_init_q, gie_clear_q, pc_load_q;
  logic        wake_resume_q, power_control_por_q;
  logic [12:0] pc_value_q, pc_seen;
  logic [7:0]  status_q;
  int          fail_count, checks_done, wake_cnt, init_cnt, n, lo, i0;
  int          gie_cnt;
  logic        ptd_tab [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [1:0]  osc_tab [5] = '{2'b11, 2'b11, 2'b00, 2'b01, 2'b10};

  prs_top #(.POWER_UP_TIMER_TICKS(PT)) prs_top_inst (
    .clk_sys                (clk_sys),
    .rst_b                  (rst_b),
    .supply_rise_det        (supply_rise_det),
    .external_reset_pin_n   (external_reset_pin_n),
    .watchdog_timer_timeout (watchdog_timer_timeout),
    .sleep_enter            (sleep_enter),
    .irq_wake               (irq_wake),
    .global_irq_enable      (global_irq_enable),
    .power_up_timer_disable (power_up_timer_disable),
    .osc_select_bits        (osc_select_bits),
    .osc_in                 (osc_in),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .pready_q               (pready_q),
    .prdata_q               (prdata_q),
    .pslverr_q              (pslverr_q),
    .core_reset_n_q         (core_reset_n_q),
    .reg_init_q             (reg_init_q),
    .gie_clear_q            (gie_clear_q),
    .pc_load_q              (pc_load_q),
    .pc_value_q             (pc_value_q),
    .wake_resume_q          (wake_resume_q),
    .status_q               (status_q),
    .power_control_por_q             (power_control_por_q)
  );
  prs_core_model prs_core_model_inst (
    .clk_sys       (clk_sys),
    .rst_b         (rst_b),
    .pc_load_q     (pc_load_q),
    .pc_value_q    (pc_value_q),
    .wake_resume_q (wake_resume_q),
    .reg_init_q    (reg_init_q),
    .gie_clear_q   (gie_clear_q),
    .osc_in        (osc_in),
    .pc_seen       (pc_seen),
    .wake_cnt      (wake_cnt),
    .init_cnt      (init_cnt),
    .gie_cnt       (gie_cnt)
  );

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // helpers
  task automatic stop_test;
    $display("checks %0d failures %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got,
               exp);
    end
  endtask
  task automatic hang(input string what);
    fail_count++;
    $display("CHECK FAILED at %0t: no %s in time", $time, what);
    stop_test();
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_sys);
      if (pready_q === 1'b1) break;
    end
    if (k == 20) hang("pready");
    rd = prdata_q;
    err = pslverr_q;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wait_rel(input int lim);
    for (n = 0; n < lim && core_reset_n_q !== 1'b1; n++) @(posedge clk_sys);
    if (n == lim) hang("release");
  endtask
  task automatic wait_wake(input int lim);
    int w0;
    w0 = wake_cnt;
    for (n = 0; n < lim && wake_cnt == w0; n++) @(posedge clk_sys);
    if (n == lim) hang("wake");
  endtask
  task automatic pin_reset(input int len);
    external_reset_pin_n <= 1'b0;
    tick(len);
    external_reset_pin_n <= 1'b1;
    tick(1);
  endtask
  task automatic go_sleep;
    sleep_enter <= 1'b1;
    tick(1);
    sleep_enter <= 1'b0;
    tick(3);
    cmp(status_q[4:3], 2'b10, "sleep flags");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst_b = 1'b0; supply_rise_det = 1'b1; external_reset_pin_n = 1'b1;
    watchdog_timer_timeout = 1'b0; sleep_enter = 1'b0; irq_wake = 1'b0;
    global_irq_enable = 1'b0; power_up_timer_disable = 1'b1;
    osc_select_bits = 2'b11; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0000_0000;
    fail_count = 0; checks_done = 0;
    tick(10);
    rst_b <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      power_up_timer_disable <= ptd_tab[i];
      osc_select_bits <= osc_tab[i];
      supply_rise_det <= 1'b1;
      tick(5);
      i0 = init_cnt;
      supply_rise_det <= 1'b0;
      tick(1);
      wait_rel(PUTC + OSTC + 400);
      lo = (ptd_tab[i] ? 0 : PUTC) + (osc_tab[i] == 2'b11 ? 0 : OSTC);
      cmp(n >= lo - lo / 20, 1, "delay short");
      cmp(n <= lo + (lo == 0 ? 6 : 200), 1, "delay long");
      tick(3);
      cmp(status_q, 8'h18, "por status");
      cmp(power_control_por_q, 1'b0, "por flag");
      cmp(pc_seen, 13'h0000, "por pc");
      cmp(init_cnt - i0, 1, "por init");
    end
    // pin held low through the delays, release starts at once
    external_reset_pin_n <= 1'b0;
    supply_rise_det <= 1'b1;
    tick(5);
    supply_rise_det <= 1'b0;
    tick(PUTC + OSTC + 300);
    cmp(core_reset_n_q, 1'b0, "pin hold");
    external_reset_pin_n <= 1'b1;
    tick(1);
    wait_rel(40);
    cmp(n <= EXT_FILT_CYC + 4, 1, "pin release");
    // registers over apb
    apb(1'b1, POWER_CONTROL_ADDR, 32'h0000_0002);
    apb(1'b0, POWER_CONTROL_ADDR, 32'h0);
    cmp(rd, 32'h0000_0002, "power_control read");
    apb(1'b1, STATUS_ADDR, 32'h0000_0000);
    apb(1'b0, STATUS_ADDR, 32'h0);
    cmp(rd, 32'h0000_0018, "status ro bits");
    apb(1'b0, 12'h004, 32'h0);
    cmp(err, 1'b1, "unmapped error");
    cmp(rd, 32'h0000_0000, "unmapped data");
    // short glitch on the pin is filtered out
    pin_reset(3);
    tick(15);
    cmp(core_reset_n_q, 1'b1, "glitch");
    pin_reset(15);
    wait_rel(40);
    cmp(status_q & 8'hF8, 8'h18, "pin run");
    cmp(power_control_por_q, 1'b1, "pin power_control");
    watchdog_timer_timeout <= 1'b1;
    tick(1);
    watchdog_timer_timeout <= 1'b0;
    tick(4);
    wait_rel(40);
    cmp(status_q & 8'hF8, 8'h08, "wdt reset");
    cmp(power_control_por_q, 1'b1, "wdt power_control");
    // wake-ups in crystal mode run the oscillator delay
    go_sleep();
    i0 = init_cnt;
    watchdog_timer_timeout <= 1'b1;
    tick(1);
    watchdog_timer_timeout <= 1'b0;
    wait_wake(OSTC + 300);
    cmp(n >= OSTC - 100, 1, "wake delay");
    tick(2);
    cmp(status_q[4:3], 2'b00, "wdt wake");
    cmp(init_cnt, i0, "wdt wake init");
    go_sleep();
    global_irq_enable <= 1'b1;
    irq_wake <= 1'b1;
    tick(1);
    irq_wake <= 1'b0;
    wait_wake(OSTC + 300);
    tick(2);
    cmp(pc_seen, 13'h0004, "irq vector");
    cmp(status_q[4:3], 2'b10, "irq wake");
    go_sleep();
    pin_reset(15);
    wait_rel(OSTC + 300);
    tick(2);
    cmp(status_q & 8'hF8, 8'h10, "pin sleep");
    cmp(pc_seen, 13'h0000, "pin sleep pc");
    // rc mode wake: no oscillator delay, no vector with enable clear
    osc_select_bits <= 2'b11;
    global_irq_enable <= 1'b0;
    go_sleep();
    irq_wake <= 1'b1;
    tick(1);
    irq_wake <= 1'b0;
    wait_wake(40);
    cmp(n <= 4, 1, "rc wake");
    tick(2);
    cmp(pc_seen, 13'h0000, "no irq vector");
    // nine releases from reset: six power-on, two pin, one watchdog
    cmp(init_cnt, 9, "reset loads");
    cmp(gie_cnt, 9, "enable clears");
    stop_test();
  end
endmodule
